// ==== rtl/glyph_pkg.sv ====
// Shared constants and carrier types for the user glyph pattern memory
package glyph_pkg;

	// ----------------------------------------------------------------
	// Widths and capacity
	// ----------------------------------------------------------------
	localparam int DOT_W = 5;
	localparam int CODE_W = 8;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 6;
	localparam int ROW_W = 4;
	localparam int DEPTH = 64;
	localparam int NARROW_GLYPHS = 8;
	localparam int WIDE_GLYPHS = 4;

	// ----------------------------------------------------------------
	// Field positions and row figures
	// ----------------------------------------------------------------
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 4;
	localparam logic [3:0] SEL_USER = 4'h0;
	localparam logic [2:0] NARROW_CURSOR_ROW = 3'h7;
	localparam logic [3:0] WIDE_CURSOR_ROW = 4'hA;
	localparam logic [2:0] UNUSED_DATA = 3'h0;
	localparam logic [4:0] ALL_DOTS = 5'h1F;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [5:0] PTR_RESET = 6'h00;
	localparam logic [4:0] DOTS_RESET = 5'h00;
	localparam logic [7:0] RD_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HOST_NONE = 2'h0,
		HOST_SET = 2'h1,
		HOST_WRITE = 2'h3,
		HOST_READ = 2'h2
	} host_op_type;

	typedef struct packed {
		host_op_type op;
		logic [5:0] addr;
		logic [7:0] data;
	} host_req_type;

	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [3:0] row;
		logic cursor;
	} lookup_req_type;

	typedef struct packed {
		logic valid;
		logic user_sel;
		logic cursor_row;
		logic [4:0] dots;
	} lookup_rsp_type;

endpackage : glyph_pkg

// ==== rtl/glyph_row_store.sv ====
// Pattern row storage: one write port, two asynchronous read ports
`timescale 1ns/1ps
module glyph_row_store (
	// Clock
	input wire logic sys_clk_i,
	input wire logic ce_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [5:0] wr_addr_i,
	input wire logic [4:0] wr_dots_i,
	// Display read port
	input wire logic [5:0] disp_addr_i,
	output logic [4:0] disp_dots_o,
	// Host read port
	input wire logic [5:0] host_addr_i,
	output logic [4:0] host_dots_o
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Pattern data has no reset; the host loads it before use
	logic [4:0] row_mem [glyph_pkg::DEPTH];

	always_ff @(posedge sys_clk_i) begin
		if (ce_i && wr_en_i) begin
			row_mem[wr_addr_i] <= wr_dots_i;
		end
	end

	assign disp_dots_o = row_mem[disp_addr_i];
	assign host_dots_o = row_mem[host_addr_i];

endmodule : glyph_row_store

// ==== rtl/address_pointer_unit.sv ====
// Address pointer: loadable, steps up or down by one
`timescale 1ns/1ps
module address_pointer_unit (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Control
	input wire logic load_i,
	input wire logic [5:0] load_addr_i,
	input wire logic step_i,
	input wire logic step_up_i,
	// State
	output logic [5:0] ptr_o
);

	logic [5:0] ptr_ff;
	logic [5:0] nxt_ptr;

	always_comb begin
		nxt_ptr = ptr_ff;
		if (load_i) begin
			nxt_ptr = load_addr_i;
		end else if (step_i) begin
			// Wraps at both ends of the 64 entries
			nxt_ptr = step_up_i ? ptr_ff + 6'h01 : ptr_ff - 6'h01;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ptr_ff <= glyph_pkg::PTR_RESET;
		end else if (ce_i) begin
			ptr_ff <= nxt_ptr;
		end
	end

	assign ptr_o = ptr_ff;

endmodule : address_pointer_unit

// ==== rtl/user_glyph_ram_lookup.sv ====
// User glyph pattern memory with host access and display row lookup
//
// Behaviour
// - The pattern memory holds eight 5x8 glyphs or four 5x10 glyphs, chosen by font size.
// - The host may overwrite any pattern entry at any time.
// - Data bits 4 to 0 of a row are the five dots, bit 4 leftmost, bit 0 rightmost.
// - In 5x8 layout code bits 2 to 0 become pattern address bits 5 to 3.
// - A stored one lights its dot and a stored zero leaves it dark.
// - In 5x8 layout address bits 2 to 0 pick the glyph row, top row first.
// - The last glyph row is the cursor row, shown as stored bits ORed with the cursor.
// - A set bit in the cursor row lights its dot whether or not the cursor is here.
// - Codes whose bits 7 to 4 are zero take their glyph from the pattern memory.
// - In 5x8 layout code bit 3 is ignored, so codes 00H and 08H show one glyph.
// - Each host write or read steps the address pointer by one, up or down by entry mode.
`timescale 1ns/1ps
module user_glyph_ram_lookup (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Configuration
	input wire logic wide_font_i,
	input wire logic entry_inc_i,
	// Host access
	input wire glyph_pkg::host_req_type host_req_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic [5:0] address_pointer_o,
	// Display lookup
	input wire glyph_pkg::lookup_req_type lookup_req_i,
	output glyph_pkg::lookup_rsp_type lookup_rsp_o
);

	// ----------------------------------------------------------------
	// Host command decode
	// ----------------------------------------------------------------
	logic host_set;
	logic host_write;
	logic host_read;
	logic [5:0] ptr;
	logic [4:0] host_dots;

	assign host_set = host_req_i.op == glyph_pkg::HOST_SET;
	assign host_write = host_req_i.op == glyph_pkg::HOST_WRITE;
	assign host_read = host_req_i.op == glyph_pkg::HOST_READ;

	address_pointer_unit u_pointer (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.load_i(host_set),
		.load_addr_i(host_req_i.addr),
		.step_i(host_write || host_read),
		.step_up_i(entry_inc_i),
		.ptr_o(ptr)
	);

	assign address_pointer_o = ptr;

	// ----------------------------------------------------------------
	// Display address mapping
	// ----------------------------------------------------------------
	logic user_sel;
	logic row_ok;
	logic cursor_row;
	logic [5:0] glyph_addr;
	logic [4:0] stored_dots;
	logic [4:0] cursor_dots;
	logic [4:0] lit_dots;

	// Only codes 00H to 0FH reach this memory
	assign user_sel = lookup_req_i.code[glyph_pkg::SEL_MSB:glyph_pkg::SEL_LSB]
		== glyph_pkg::SEL_USER;

	always_comb begin
		if (wide_font_i) begin
			// Four glyphs of sixteen row slots; code bits 0 and 3 unused
			glyph_addr = {lookup_req_i.code[2:1], lookup_req_i.row};
			row_ok = lookup_req_i.row <= glyph_pkg::WIDE_CURSOR_ROW;
			cursor_row = lookup_req_i.row == glyph_pkg::WIDE_CURSOR_ROW;
		end else begin
			// Eight glyphs of eight rows; code bit 3 never reaches the address
			glyph_addr = {lookup_req_i.code[2:0], lookup_req_i.row[2:0]};
			row_ok = !lookup_req_i.row[3];
			cursor_row = row_ok && (lookup_req_i.row[2:0] == glyph_pkg::NARROW_CURSOR_ROW);
		end
	end

	// ----------------------------------------------------------------
	// Pattern storage
	// ----------------------------------------------------------------
	glyph_row_store u_store (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.wr_en_i(host_write),
		.wr_addr_i(ptr),
		.wr_dots_i(host_req_i.data[4:0]),
		.disp_addr_i(glyph_addr),
		.disp_dots_o(stored_dots),
		.host_addr_i(ptr),
		.host_dots_o(host_dots)
	);

	// ----------------------------------------------------------------
	// Dot merge
	// ----------------------------------------------------------------
	// Cursor row is ORed, not replaced, so stray stored bits stay lit
	assign cursor_dots = (cursor_row && lookup_req_i.cursor) ? glyph_pkg::ALL_DOTS
		: glyph_pkg::DOTS_RESET;
	// Bit 4 stays leftmost all the way to the output
	assign lit_dots = (user_sel && row_ok) ? (stored_dots | cursor_dots)
		: glyph_pkg::DOTS_RESET;

	// ----------------------------------------------------------------
	// Lookup response register
	// ----------------------------------------------------------------
	glyph_pkg::lookup_rsp_type rsp_ff;
	glyph_pkg::lookup_rsp_type nxt_rsp;

	always_comb begin
		nxt_rsp = rsp_ff;
		nxt_rsp.valid = lookup_req_i.valid;
		if (lookup_req_i.valid) begin
			nxt_rsp.user_sel = user_sel;
			nxt_rsp.cursor_row = cursor_row && user_sel;
			nxt_rsp.dots = lit_dots;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rsp_ff <= '0;
		end else if (ce_i) begin
			rsp_ff <= nxt_rsp;
		end
	end

	assign lookup_rsp_o = rsp_ff;

	// ----------------------------------------------------------------
	// Host read data register
	// ----------------------------------------------------------------
	logic [7:0] rd_data_ff;
	logic [7:0] nxt_rd_data;
	logic rd_valid_ff;
	logic nxt_rd_valid;

	always_comb begin
		nxt_rd_data = rd_data_ff;
		nxt_rd_valid = host_read;
		if (host_read) begin
			// Upper bits are not kept and read back as zero
			nxt_rd_data = {glyph_pkg::UNUSED_DATA, host_dots};
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_ff <= glyph_pkg::RD_RESET;
			rd_valid_ff <= 1'b0;
		end else if (ce_i) begin
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	assign rd_data_o = rd_data_ff;
	assign rd_valid_o = rd_valid_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	sequence plain_row_s;
		ce_i && lookup_req_i.valid && user_sel && row_ok && !cursor_row;
	endsequence

	sequence cursor_row_s;
		ce_i && lookup_req_i.valid && user_sel && cursor_row;
	endsequence

	sequence host_step_s;
		ce_i && (host_write || host_read);
	endsequence

	plain_dots_a: assert property (plain_row_s |=>
		lookup_rsp_o.valid && lookup_rsp_o.dots == $past(stored_dots))
		else $error("plain row dots differ from stored row");

	cursor_merge_a: assert property (cursor_row_s |=>
		lookup_rsp_o.dots == ($past(stored_dots) | ($past(lookup_req_i.cursor)
		? glyph_pkg::ALL_DOTS : glyph_pkg::DOTS_RESET)))
		else $error("cursor row is not stored OR cursor");

	stray_cursor_a: assert property (cursor_row_s ##0 !lookup_req_i.cursor |=>
		lookup_rsp_o.cursor_row && lookup_rsp_o.dots == $past(stored_dots))
		else $error("stored cursor row bits not shown without cursor");

	rom_code_a: assert property (ce_i && lookup_req_i.valid && !user_sel |=>
		!lookup_rsp_o.user_sel && lookup_rsp_o.dots == glyph_pkg::DOTS_RESET)
		else $error("font code reached the user pattern path");

	narrow_map_a: assert property (ce_i && lookup_req_i.valid && !wide_font_i |->
		glyph_addr == {lookup_req_i.code[2:0], lookup_req_i.row[2:0]})
		else $error("5x8 pattern address mapping wrong");

	wide_map_a: assert property (ce_i && lookup_req_i.valid && wide_font_i |->
		glyph_addr[5:4] == lookup_req_i.code[2:1]
		&& (cursor_row == (lookup_req_i.row == glyph_pkg::WIDE_CURSOR_ROW)))
		else $error("5x10 pattern address mapping wrong");

	pointer_step_a: assert property (host_step_s |=>
		address_pointer_o == ($past(entry_inc_i) ? 6'($past(address_pointer_o) + 6'h01)
		: 6'($past(address_pointer_o) - 6'h01)))
		else $error("address pointer did not step by one");

	read_upper_a: assert property (ce_i && host_read |=>
		rd_valid_o && rd_data_o == {glyph_pkg::UNUSED_DATA, $past(host_dots)})
		else $error("read data wrong or upper bits not zero");

	write_back_a: assert property (ce_i && host_set ##1 ce_i && host_write
		##1 ce_i && host_set && host_req_i.addr == $past(address_pointer_o)
		##1 ce_i && host_read |=> rd_data_o[4:0] == $past(host_req_i.data[4:0], 3))
		else $error("written pattern row not read back");

	// ----------------------------------------------------------------
	// Hold, freeze, dark row, cursor, flag and pointer checks
	// ----------------------------------------------------------------
	sequence idle_lookup_s;
		ce_i && !lookup_req_i.valid;
	endsequence

	sequence dark_row_s;
		ce_i && lookup_req_i.valid
			&& (wide_font_i ? lookup_req_i.row > glyph_pkg::WIDE_CURSOR_ROW
			: lookup_req_i.row[3]);
	endsequence

	sequence lit_cursor_s;
		ce_i && lookup_req_i.valid && user_sel && lookup_req_i.cursor;
	endsequence

	rsp_pulse_a: assert property (idle_lookup_s |=> !lookup_rsp_o.valid)
		else $error("lookup valid stood after an idle cycle");

	rsp_hold_a: assert property (idle_lookup_s |=>
		$stable(lookup_rsp_o.dots) && $stable(lookup_rsp_o.user_sel)
		&& $stable(lookup_rsp_o.cursor_row))
		else $error("lookup result changed without a request");

	dark_row_a: assert property (dark_row_s |=>
		lookup_rsp_o.dots == glyph_pkg::DOTS_RESET)
		else $error("row outside the glyph was not dark");

	narrow_cursor_a: assert property (lit_cursor_s ##0 !wide_font_i
		##0 lookup_req_i.row == {1'b0, glyph_pkg::NARROW_CURSOR_ROW}
		|=> lookup_rsp_o.dots == glyph_pkg::ALL_DOTS)
		else $error("5x8 cursor row not fully lit under the cursor");

	wide_cursor_a: assert property (lit_cursor_s ##0 wide_font_i
		##0 lookup_req_i.row == glyph_pkg::WIDE_CURSOR_ROW
		|=> lookup_rsp_o.dots == glyph_pkg::ALL_DOTS)
		else $error("5x10 cursor row not fully lit under the cursor");

	cursor_place_a: assert property (ce_i && lookup_req_i.valid && !wide_font_i
		&& lookup_req_i.row != {1'b0, glyph_pkg::NARROW_CURSOR_ROW}
		|=> !lookup_rsp_o.cursor_row)
		else $error("5x8 cursor flag on a body row");

	rom_cursor_a: assert property (ce_i && lookup_req_i.valid
		&& lookup_req_i.code[glyph_pkg::SEL_MSB:glyph_pkg::SEL_LSB] != glyph_pkg::SEL_USER
		|=> !lookup_rsp_o.cursor_row)
		else $error("font code flagged as a cursor row");

	user_flag_a: assert property (ce_i && lookup_req_i.valid
		&& lookup_req_i.code[glyph_pkg::SEL_MSB:glyph_pkg::SEL_LSB] == glyph_pkg::SEL_USER
		|=> lookup_rsp_o.user_sel)
		else $error("user code not routed to the pattern memory");

	pointer_load_a: assert property (ce_i && host_set |=>
		address_pointer_o == $past(host_req_i.addr))
		else $error("address pointer did not take the set address");

	pointer_idle_a: assert property (ce_i && host_req_i.op == glyph_pkg::HOST_NONE |=>
		$stable(address_pointer_o))
		else $error("address pointer moved without a host command");

	read_pulse_a: assert property (ce_i && !host_read |=> !rd_valid_o)
		else $error("read valid stood longer than one cycle");

	read_hold_a: assert property (ce_i && !host_read |=> $stable(rd_data_o))
		else $error("read data changed without a read");

	read_zero_a: assert property (rd_valid_o |->
		rd_data_o[7:5] == glyph_pkg::UNUSED_DATA)
		else $error("unused read bits not zero");

	freeze_state_a: assert property (!ce_i |=> $stable(address_pointer_o) && $stable(rd_data_o)
		&& $stable(rd_valid_o) && $stable(lookup_rsp_o))
		else $error("state moved while the clock enable was low");

endmodule : user_glyph_ram_lookup

// ==== testbench/glyph_host_model.sv ====
// Host model that loads pattern rows through the command port
`timescale 1ns/1ps
module glyph_host_model (
	// Clock
	input wire logic sys_clk_i,
	// Command port
	output glyph_pkg::host_req_type host_req_o
);
	initial begin
		host_req_o = '{op: glyph_pkg::HOST_NONE, addr: 6'h00, data: 8'h00};
	end

	task automatic put(input glyph_pkg::host_op_type kind, input logic [5:0] a,
		input logic [7:0] d);
		@(posedge sys_clk_i);
		host_req_o <= '{op: kind, addr: a, data: d};
	endtask : put

	// Idle fields carry no meaning, so they are scrambled
	task automatic rest();
		@(posedge sys_clk_i);
		host_req_o <= '{op: glyph_pkg::HOST_NONE, addr: ~host_req_o.addr,
			data: ~host_req_o.data};
	endtask : rest

	task automatic load_glyph(input logic [2:0] g, input logic [34:0] rows);
		put(glyph_pkg::HOST_SET, {g, 3'h0}, 8'h00);
		for (int r = 0; r < 7; r++) begin
			put(glyph_pkg::HOST_WRITE, 6'h00, {3'h5, rows[r*5 +: 5]});
		end
		put(glyph_pkg::HOST_WRITE, 6'h00, 8'h00);
		rest();
	endtask : load_glyph
endmodule : glyph_host_model

// ==== testbench/tb_user_glyph_ram_lookup.sv ====
// Self-checking bench for the user glyph pattern memory
`timescale 1ns/1ps
module tb_user_glyph_ram_lookup;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i = 1'b1;
	logic wide_font_i = 1'b0;
	logic entry_inc_i = 1'b1;
	glyph_pkg::host_req_type host_req;
	logic [7:0] rd_data;
	logic rd_valid;
	logic [5:0] ptr;
	glyph_pkg::lookup_req_type lookup_req = '0;
	glyph_pkg::lookup_rsp_type lookup_rsp;
	logic [4:0] shadow [64];
	int err_count = 0;
	int check_count = 0;

	always #20 sys_clk_i = ~sys_clk_i;

	user_glyph_ram_lookup u_user_glyph_ram_lookup (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .wide_font_i(wide_font_i), .entry_inc_i(entry_inc_i),
		.host_req_i(host_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.address_pointer_o(ptr), .lookup_req_i(lookup_req), .lookup_rsp_o(lookup_rsp));

	glyph_host_model u_glyph_host_model (.sys_clk_i(sys_clk_i), .host_req_o(host_req));

	// ----
	// Checks
	// ----
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	function automatic logic [4:0] pat(input int g, input int r);
		return 5'((g * 11 + r * 7 + 3) % 32);
	endfunction : pat

	// ----
	// Scenarios
	// ----
	task automatic test_load();
		logic [34:0] rows;
		for (int g = 0; g < 8; g++) begin
			for (int r = 0; r < 7; r++) begin
				rows[r*5 +: 5] = pat(g, r);
				shadow[g*8+r] = pat(g, r);
			end
			shadow[g*8+7] = 5'h00;
			u_glyph_host_model.load_glyph(3'(g), rows);
			#1;
			chk({2'h0, ptr}, 8'(((g + 1) * 8) % 64));
		end
	endtask : test_load

	// Overwrite a body row and, on purpose, the cursor row of glyph 2
	task automatic test_rewrite();
		u_glyph_host_model.put(glyph_pkg::HOST_SET, 6'h17, 8'h00);
		u_glyph_host_model.put(glyph_pkg::HOST_WRITE, 6'h00, 8'hF5);
		u_glyph_host_model.put(glyph_pkg::HOST_SET, 6'h2B, 8'h00);
		u_glyph_host_model.put(glyph_pkg::HOST_WRITE, 6'h00, 8'h1F);
		u_glyph_host_model.rest();
		shadow[23] = 5'h15;
		shadow[43] = 5'h1F;
		#1;
		chk({2'h0, ptr}, 8'h2C);
	endtask : test_rewrite

	// Write then read the same row in back-to-back commands
	task automatic test_write_back();
		u_glyph_host_model.put(glyph_pkg::HOST_SET, 6'h30, 8'h00);
		u_glyph_host_model.put(glyph_pkg::HOST_WRITE, 6'h00, 8'hE6);
		u_glyph_host_model.put(glyph_pkg::HOST_SET, 6'h30, 8'h00);
		u_glyph_host_model.put(glyph_pkg::HOST_READ, 6'h00, 8'h00);
		u_glyph_host_model.rest();
		shadow[48] = 5'h06;
		#1;
		chk(rd_data, 8'h06);
		chk({2'h0, ptr}, 8'h31);
	endtask : test_write_back

	task automatic read_at(input logic [5:0] a, input logic [5:0] next_ptr);
		u_glyph_host_model.put(glyph_pkg::HOST_SET, a, 8'h00);
		u_glyph_host_model.put(glyph_pkg::HOST_READ, 6'h00, 8'h00);
		u_glyph_host_model.rest();
		#1;
		chk(8'(rd_valid), 8'h01);
		chk(rd_data, {3'h0, shadow[a]});
		chk({2'h0, ptr}, {2'h0, next_ptr});
	endtask : read_at

	task automatic test_read_down();
		@(posedge sys_clk_i);
		entry_inc_i <= 1'b0;
		read_at(6'h00, 6'h3F);
		read_at(6'h2B, 6'h2A);
		read_at(6'h17, 6'h16);
		@(posedge sys_clk_i);
		entry_inc_i <= 1'b1;
		read_at(6'h0D, 6'h0E);
	endtask : test_read_down

	// Clock enable low drops host commands; a mid-run reset clears the outputs
	task automatic test_freeze_reset();
		@(posedge sys_clk_i);
		ce_i <= 1'b0;
		u_glyph_host_model.put(glyph_pkg::HOST_SET, 6'h21, 8'h00);
		u_glyph_host_model.put(glyph_pkg::HOST_WRITE, 6'h00, 8'h0A);
		u_glyph_host_model.rest();
		#1;
		chk({2'h0, ptr}, 8'h0E);
		@(posedge sys_clk_i);
		ce_i <= 1'b1;
		read_at(6'h0E, 6'h0F);
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk({2'h0, ptr}, 8'h00);
		chk({7'h00, rd_valid}, 8'h00);
		chk(rd_data, 8'h00);
		@(posedge sys_clk_i);
		reset_i <= 1'b0;
	endtask : test_freeze_reset

	task automatic look(input logic [7:0] code, input logic [3:0] row, input logic cur);
		logic [5:0] a;
		logic [4:0] want;
		logic user;
		logic crow;
		user = (code[7:4] == 4'h0);
		a = wide_font_i ? {code[2:1], row} : {code[2:0], row[2:0]};
		crow = user && (row == (wide_font_i ? 4'hA : 4'h7));
		want = user ? shadow[a] : 5'h00;
		if (crow && cur) begin
			want = 5'h1F;
		end
		if (row > (wide_font_i ? 4'hA : 4'h7)) begin
			want = 5'h00;
		end
		@(posedge sys_clk_i);
		lookup_req <= '{valid: 1'b1, code: code, row: row, cursor: cur};
		@(posedge sys_clk_i);
		lookup_req <= '{valid: 1'b0, code: ~code, row: ~row, cursor: ~cur};
		#1;
		chk(8'(lookup_rsp.valid), 8'h01);
		chk({3'h0, lookup_rsp.dots}, {3'h0, want});
		chk(8'(lookup_rsp.user_sel), 8'(user));
		chk(8'(lookup_rsp.cursor_row), 8'(crow));
	endtask : look

	task automatic test_lookup();
		for (int w = 0; w < 2; w++) begin
			@(posedge sys_clk_i);
			wide_font_i <= w[0];
			@(posedge sys_clk_i);
			for (int c = 0; c < 16; c++) begin
				for (int r = 0; r < 16; r++) begin
					look(8'(c), 4'(r), 1'b0);
					look(8'(c), 4'(r), 1'b1);
				end
			end
			for (int k = 4; k < 8; k++) begin
				look(8'(1 << k) | 8'h02, 4'h7, 1'b1);
			end
		end
	endtask : test_lookup

	initial begin
		#(40 * 8000);
		err_count++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		test_load();
		test_rewrite();
		test_write_back();
		test_read_down();
		test_freeze_reset();
		test_lookup();
		tally_and_finish();
	end
endmodule : tb_user_glyph_ram_lookup
